// >>> shared/eqfir_consts.svh
// Named offsets, fields, reset values and counts of the equalizer block
// Assumes byte addresses on an Avalon-MM slave with 32-bit data
`ifndef EQFIR_CONSTS_SVH
`define EQFIR_CONSTS_SVH
`define EQFIR_TAPS        9
`define EQFIR_CENTER      4
`define EQFIR_FRAC        16
`define EQFIR_FIFO_DEPTH  4
`define EQFIR_OFS_CTRL    8'h00
`define EQFIR_OFS_STATUS  8'h04
`define EQFIR_OFS_BANK_A  8'h40
`define EQFIR_OFS_BANK_B  8'h80
`define EQFIR_BANK_MASK   8'hc3
`define EQFIR_MODE_LSB    0
`define EQFIR_MODE_MSB    1
`define EQFIR_SHARE_BIT   2
`define EQFIR_MERGE_BIT   3
`define EQFIR_WSEL_LSB    4
`define EQFIR_WSEL_MSB    6
`define EQFIR_MODE_OFF    2'h0
`define EQFIR_MODE_ON     2'h2
`define EQFIR_CTRL_RST    7'h00
`define EQFIR_WSEL_MAX    3'h6
`define EQFIR_STAT_LVL    2
`define EQFIR_SAT_MAX     40'sh7ff
`define EQFIR_SAT_MIN     -40'sh800
`endif

// >>> shared/eqfir_pkg.sv
// Types shared by the equalizer modules
// Assumes 12-bit converter samples and 18-bit coefficient words
package eqfir_pkg;
  typedef enum logic [1:0] {
    EQFIR_BYPASS,
    EQFIR_DUAL,
    EQFIR_SINGLE,
    EQFIR_TVAR
  } eqfir_mode_e;
  typedef logic [8:0][11:0] eqfir_win_t;
  typedef logic [8:0][17:0] eqfir_bank_t;
  typedef logic signed [39:0] eqfir_acc_t;
endpackage

// >>> shared/eqfir_stream_if.sv
// Valid/ready word stream between the filter core and its output FIFO
// Assumes one clock shared by both ends
`timescale 1ns/1ps
`default_nettype none
interface eqfir_stream_if #(parameter int W = 24);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> logic/eqfir_fifo.sv
// Flip-flop FIFO with valid/ready on both sides
// Assumes synchronous active-low reset; depth need not be a power of two
`timescale 1ns/1ps
`default_nettype none
module eqfir_fifo #(
  parameter int W     = 24,
  parameter int DEPTH = 4,
  parameter int AW    = $clog2(DEPTH)
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rstn_in,
  // Streams
  eqfir_stream_if.snk     wr,
  eqfir_stream_if.src     rd,
  // Fill level
  output logic [AW:0]     level_out
);
  logic [DEPTH-1:0][W-1:0] mem;
  logic [DEPTH-1:0][W-1:0] next_mem;
  logic [AW-1:0]           wr_ptr;
  logic [AW-1:0]           next_wr_ptr;
  logic [AW-1:0]           rd_ptr;
  logic [AW-1:0]           next_rd_ptr;
  logic [AW:0]             count;
  logic [AW:0]             next_count;
  logic                    push;
  logic                    pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
  endfunction

  // Honest full and empty from the count
  assign wr.ready  = (count != (AW + 1)'(DEPTH));
  assign rd.valid  = (count != '0);
  assign rd.data   = mem[rd_ptr];
  assign level_out = count;
  assign push      = wr.valid && wr.ready;
  assign pop       = rd.valid && rd.ready;

  // Next pointers, count and storage
  always_comb begin
    next_mem    = mem;
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    next_count  = count;
    if (push) begin
      next_mem[wr_ptr] = wr.data;
      next_wr_ptr      = bump(wr_ptr);
    end
    if (pop) begin
      next_rd_ptr = bump(rd_ptr);
    end
    if (push && !pop) begin
      next_count = count + 1'b1;
    end else if (pop && !push) begin
      next_count = count - 1'b1;
    end
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mem    <= '0;
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      mem    <= next_mem;
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count  <= next_count;
    end
  end

  a_fifo_bound: assert property (@(posedge clk_in) disable iff (!rstn_in)
    count <= (AW + 1)'(DEPTH) && !(count == '0 && pop))
    else $error("FIFO count out of range");
endmodule
`default_nettype wire

// >>> logic/eqfir_top.sv
// Programmable 9-tap equalizer with Avalon-MM registers and output FIFO
// Assumes one 10 MHz clock, synchronous active-low reset, 2 samples per word
`timescale 1ns/1ps
`default_nettype none
`include "eqfir_consts.svh"
module eqfir_top #(
  parameter int SW = 12
) (
  // Clock and reset
  input  wire logic          clk_in,
  input  wire logic          rstn_in,
  // Avalon-MM slave
  input  wire logic [7:0]    avs_address_in,
  input  wire logic          avs_read_in,
  input  wire logic          avs_write_in,
  input  wire logic [31:0]   avs_writedata_in,
  input  wire logic [3:0]    avs_byteenable_in,
  output logic      [31:0]   avs_readdata_out,
  output logic               avs_waitrequest_out,
  // Samples from the converter core
  input  wire logic          smp_valid_in,
  input  wire logic [SW-1:0] smp_a_in,
  input  wire logic [SW-1:0] smp_b_in,
  output logic               smp_ready_out,
  // Samples toward the down-converter path
  output logic               eq_valid_out,
  output logic      [SW-1:0] eq_a_out,
  output logic      [SW-1:0] eq_b_out,
  input  wire logic          eq_ready_in
);
  localparam int LW = $clog2(`EQFIR_FIFO_DEPTH) + 1;

  eqfir_stream_if #(.W(2 * SW)) to_fifo ();
  eqfir_stream_if #(.W(2 * SW)) from_fifo ();

  logic [6:0]              ctrl;
  logic [6:0]              next_ctrl;
  eqfir_pkg::eqfir_bank_t  bank_a;
  eqfir_pkg::eqfir_bank_t  next_bank_a;
  eqfir_pkg::eqfir_bank_t  bank_b;
  eqfir_pkg::eqfir_bank_t  next_bank_b;
  logic [31:0]             next_rdata;
  logic                    next_wait;
  logic                    h_valid;
  logic                    next_h_valid;
  logic [SW-1:0]           h_a;
  logic [SW-1:0]           next_h_a;
  logic [SW-1:0]           h_b;
  logic [SW-1:0]           next_h_b;
  logic [7:0][SW-1:0]      pa;
  logic [7:0][SW-1:0]      next_pa;
  logic [7:0][SW-1:0]      pb;
  logic [7:0][SW-1:0]      next_pb;
  logic                    next_in_ready;
  logic                    next_eq_valid;
  logic [SW-1:0]           next_eq_a;
  logic [SW-1:0]           next_eq_b;
  logic [LW-1:0]           fifo_level;
  eqfir_pkg::eqfir_mode_e  mode;
  eqfir_pkg::eqfir_win_t   win_a;
  eqfir_pkg::eqfir_win_t   win_b;
  logic [SW-1:0]           res_a;
  logic [SW-1:0]           res_b;
  logic                    push;
  logic                    take;
  logic                    bus_go;
  logic                    hit_a;
  logic                    hit_b;
  logic [3:0]              idx;

  // Mode decode from the control word
  function automatic eqfir_pkg::eqfir_mode_e decode(input logic [6:0] c);
    if (c[`EQFIR_MODE_MSB:`EQFIR_MODE_LSB] != `EQFIR_MODE_ON) begin
      return eqfir_pkg::EQFIR_BYPASS;
    end
    case ({c[`EQFIR_SHARE_BIT], c[`EQFIR_MERGE_BIT]})
      2'h0:    return eqfir_pkg::EQFIR_DUAL;
      2'h3:    return eqfir_pkg::EQFIR_SINGLE;
      2'h1:    return eqfir_pkg::EQFIR_TVAR;
      default: return eqfir_pkg::EQFIR_BYPASS;
    endcase
  endfunction

  // Nine-tap sum with saturation to the sample width
  function automatic logic [SW-1:0] fir(input eqfir_pkg::eqfir_win_t w,
                                        input eqfir_pkg::eqfir_bank_t cf,
                                        input logic [2:0] wsel);
    eqfir_pkg::eqfir_acc_t acc;
    eqfir_pkg::eqfir_acc_t prod;
    logic [2:0]            sh;
    acc = '0;
    prod = '0;
    // Code 0 is the coarsest step, codes past 6 clamp to the finest
    sh = (wsel > `EQFIR_WSEL_MAX) ? 3'h0 : 3'(`EQFIR_WSEL_MAX - wsel);
    for (int i = 0; i < `EQFIR_TAPS; i++) begin
      if (i == `EQFIR_CENTER) begin
        prod = eqfir_pkg::eqfir_acc_t'($signed(w[i])) *
               eqfir_pkg::eqfir_acc_t'($signed(cf[i]));
      end else begin
        prod = (eqfir_pkg::eqfir_acc_t'($signed(w[i])) *
                eqfir_pkg::eqfir_acc_t'($signed(cf[i][11:0]))) <<< sh;
      end
      acc = acc + prod;
    end
    acc = acc >>> `EQFIR_FRAC;
    if (acc > `EQFIR_SAT_MAX) begin
      return SW'(`EQFIR_SAT_MAX);
    end else if (acc < `EQFIR_SAT_MIN) begin
      return SW'(`EQFIR_SAT_MIN);
    end
    return acc[SW-1:0];
  endfunction

  // Byte-lane merge for register writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = wd[8*i +: 8];
    end
    return r;
  endfunction

  // Sample windows per mode
  always_comb begin
    mode  = decode(ctrl);
    win_a = '0;
    win_b = '0;
    win_a[0] = h_a;
    win_b[0] = h_b;
    for (int i = 1; i < `EQFIR_TAPS; i++) begin
      if (mode == eqfir_pkg::EQFIR_DUAL) begin
        win_a[i] = pa[i-1];
        win_b[i] = pb[i-1];
      end else begin
        // Interleaved stream: a then b in each word
        win_a[i] = (i % 2 == 1) ? pb[(i-1)/2] : pa[i/2-1];
        win_b[i] = (i == 1) ? h_a : ((i % 2 == 0) ? pb[i/2-1] : pa[(i-3)/2]);
      end
    end
    res_a = fir(win_a, bank_a, ctrl[`EQFIR_WSEL_MSB:`EQFIR_WSEL_LSB]);
    // Second sample of a word takes the second set in time varying mode
    res_b = fir(win_b, (mode == eqfir_pkg::EQFIR_SINGLE) ? bank_a : bank_b,
                ctrl[`EQFIR_WSEL_MSB:`EQFIR_WSEL_LSB]);
  end

  // Filter core to FIFO
  assign to_fifo.valid = h_valid;
  assign to_fifo.data  = (mode == eqfir_pkg::EQFIR_BYPASS) ? {h_b, h_a} :
                         {res_b, res_a};
  assign push          = h_valid && to_fifo.ready;
  assign take          = smp_valid_in && smp_ready_out;
  assign from_fifo.ready = !eq_valid_out || eq_ready_in;
  assign bus_go        = (avs_read_in || avs_write_in) && !avs_waitrequest_out;
  assign idx           = avs_address_in[5:2];
  assign hit_a = ((avs_address_in & `EQFIR_BANK_MASK) == `EQFIR_OFS_BANK_A) &&
                 (idx < 4'(`EQFIR_TAPS));
  assign hit_b = ((avs_address_in & `EQFIR_BANK_MASK) == `EQFIR_OFS_BANK_B) &&
                 (idx < 4'(`EQFIR_TAPS));

  eqfir_fifo #(.W(2 * SW), .DEPTH(`EQFIR_FIFO_DEPTH)) u_fifo (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .wr        (to_fifo),
    .rd        (from_fifo),
    .level_out (fifo_level)
  );

  // Next state for bus, holding stage, history and output
  always_comb begin
    next_ctrl   = ctrl;
    next_bank_a = bank_a;
    next_bank_b = bank_b;
    next_rdata  = avs_readdata_out;
    next_wait   = !((avs_read_in || avs_write_in) && avs_waitrequest_out);
    if ((avs_read_in || avs_write_in) && avs_waitrequest_out) begin
      next_rdata = '0;
      if (avs_address_in == `EQFIR_OFS_CTRL) next_rdata = 32'(ctrl);
      if (avs_address_in == `EQFIR_OFS_STATUS) begin
        next_rdata = 32'({fifo_level, mode});
      end
      if (hit_a) next_rdata = 32'(bank_a[idx]);
      if (hit_b) next_rdata = 32'(bank_b[idx]);
    end
    if (bus_go && avs_write_in) begin
      if (avs_address_in == `EQFIR_OFS_CTRL) begin
        next_ctrl = 7'(merge(32'(ctrl), avs_writedata_in, avs_byteenable_in));
      end
      if (hit_a) begin
        next_bank_a[idx] = 18'(merge(32'(bank_a[idx]), avs_writedata_in,
                                     avs_byteenable_in));
      end
      if (hit_b) begin
        next_bank_b[idx] = 18'(merge(32'(bank_b[idx]), avs_writedata_in,
                                     avs_byteenable_in));
      end
    end
    next_h_valid  = (h_valid && !push) || take;
    next_in_ready = !next_h_valid;
    next_h_a = take ? smp_a_in : h_a;
    next_h_b = take ? smp_b_in : h_b;
    next_pa  = pa;
    next_pb  = pb;
    if (push) begin
      next_pa = {pa[6:0], h_a};
      next_pb = {pb[6:0], h_b};
    end
    next_eq_valid = eq_valid_out;
    next_eq_a     = eq_a_out;
    next_eq_b     = eq_b_out;
    if (from_fifo.ready) begin
      next_eq_valid = from_fifo.valid;
      if (from_fifo.valid) begin
        {next_eq_b, next_eq_a} = from_fifo.data;
      end
    end
  end

  // Registers
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      ctrl                <= `EQFIR_CTRL_RST;
      bank_a              <= '0;
      bank_b              <= '0;
      avs_readdata_out    <= '0;
      avs_waitrequest_out <= 1'b1;
      h_valid             <= 1'b0;
      h_a                 <= '0;
      h_b                 <= '0;
      pa                  <= '0;
      pb                  <= '0;
      smp_ready_out       <= 1'b0;
      eq_valid_out        <= 1'b0;
      eq_a_out            <= '0;
      eq_b_out            <= '0;
    end else begin
      ctrl                <= next_ctrl;
      bank_a              <= next_bank_a;
      bank_b              <= next_bank_b;
      avs_readdata_out    <= next_rdata;
      avs_waitrequest_out <= next_wait;
      h_valid             <= next_h_valid;
      h_a                 <= next_h_a;
      h_b                 <= next_h_b;
      pa                  <= next_pa;
      pb                  <= next_pb;
      smp_ready_out       <= next_in_ready;
      eq_valid_out        <= next_eq_valid;
      eq_a_out            <= next_eq_a;
      eq_b_out            <= next_eq_b;
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_req_wait;
    (avs_read_in || avs_write_in) && avs_waitrequest_out;
  endsequence
  sequence s_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  a_bus_answer: assert property (s_req_wait |=> s_ack)
    else $error("Bus answer not after one wait cycle");
  a_bypass_pass: assert property (push && ctrl[1:0] == `EQFIR_MODE_OFF |->
    to_fifo.data == {h_b, h_a})
    else $error("Bypass altered a sample");
  a_off_decode: assert property (ctrl[1:0] == `EQFIR_MODE_OFF |->
    mode == eqfir_pkg::EQFIR_BYPASS)
    else $error("Mode 0 did not disable");
  a_dual_decode: assert property (ctrl[3:0] == 4'h2 |-> mode == eqfir_pkg::EQFIR_DUAL)
    else $error("Dual mode not decoded");
  a_hist_shift: assert property (push |=> pa[0] == $past(h_a) && pb[0] == $past(h_b))
    else $error("History did not shift");
  a_unit_center: assert property (push && mode != eqfir_pkg::EQFIR_BYPASS &&
    bank_a == eqfir_pkg::eqfir_bank_t'(18'h10000) << (18 * `EQFIR_CENTER) &&
    bank_b == bank_a |->
    to_fifo.data == {win_b[`EQFIR_CENTER], win_a[`EQFIR_CENTER]})
    else $error("Unit center tap not transparent");
  a_bank_write: assert property (bus_go && avs_write_in && hit_b &&
    avs_byteenable_in == 4'hf |=> bank_b[$past(idx)] == $past(avs_writedata_in[17:0]))
    else $error("Coefficient write lost");
  a_accept_hold: assert property (take |=> h_valid && h_a == $past(smp_a_in) ##1
    ($past(push) || h_valid))
    else $error("Accepted sample not held");
  a_no_overrun: assert property (h_valid && !to_fifo.ready |=> h_a == $past(h_a))
    else $error("Held sample overwritten under back-pressure");
endmodule
`default_nettype wire

// >>> bench/eqfir_far_end.sv
// Far-end model: converter core word source and down-converter sink
// Assumes valid/ready streams on the one rising-edge clock
`timescale 1ns/1ps
`default_nettype none
module eqfir_far_end (
  // Clock and bench control
  input  wire logic        clk_in,
  input  wire logic        stall_in,
  // Word source
  output logic             smp_valid_out,
  output logic [11:0]      smp_a_out,
  output logic [11:0]      smp_b_out,
  input  wire logic        smp_ready_in,
  // Word sink
  input  wire logic        eq_valid_in,
  input  wire logic [11:0] eq_a_in,
  input  wire logic [11:0] eq_b_in,
  output logic             eq_ready_out
);
  logic [23:0] got[$];
  int          timeouts;
  // Idle lines at time zero
  initial begin
    smp_valid_out = 1'b0;
    smp_a_out = 12'h000;
    smp_b_out = 12'h000;
    eq_ready_out = 1'b0;
    timeouts = 0;
  end
  // Sink logs taken words; ready follows the stall request
  always @(posedge clk_in) begin
    if (eq_valid_in && eq_ready_out) got.push_back({eq_a_in, eq_b_in});
    eq_ready_out <= !stall_in;
  end
  // Source holds a word until taken, then scrambles the released lines
  task automatic send(input logic [11:0] a, input logic [11:0] b);
    int n;
    @(posedge clk_in);
    smp_valid_out <= 1'b1;
    smp_a_out <= a;
    smp_b_out <= b;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (smp_ready_in !== 1'b1 && n < 100);
    if (smp_ready_in !== 1'b1) timeouts++;
    smp_valid_out <= 1'b0;
    smp_a_out <= ~a;
    smp_b_out <= ~b;
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
// Self-checking bench: registers, modes, tap weights, output FIFO
// Assumes the far-end model drives both sample streams
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clk_in, rstn_in, stall, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [7:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out;
  logic [3:0]  avs_byteenable_in;
  logic        smp_valid_in, smp_ready_out, eq_valid_out, eq_ready_in;
  logic [11:0] smp_a_in, smp_b_in, eq_a_out, eq_b_out;
  int          n_fail, comparisons;
  // Design and far end
  eqfir_top #(.SW(12)) u_dut (.clk_in(clk_in), .rstn_in(rstn_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out), .smp_valid_in(smp_valid_in),
    .smp_a_in(smp_a_in), .smp_b_in(smp_b_in), .smp_ready_out(smp_ready_out),
    .eq_valid_out(eq_valid_out), .eq_a_out(eq_a_out), .eq_b_out(eq_b_out),
    .eq_ready_in(eq_ready_in));
  eqfir_far_end u_far (.clk_in(clk_in), .stall_in(stall), .smp_valid_out(smp_valid_in),
    .smp_a_out(smp_a_in), .smp_b_out(smp_b_in), .smp_ready_in(smp_ready_out),
    .eq_valid_in(eq_valid_out), .eq_a_in(eq_a_out), .eq_b_in(eq_b_out),
    .eq_ready_out(eq_ready_in));
  // 10 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Counts and verdict
  task automatic report_and_stop();
    n_fail += u_far.timeouts;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", what, e, g);
      n_fail++;
    end
  endtask
  task automatic timeout(input string what);
    $display("ERROR %s expected done seen timeout", what);
    n_fail++;
    report_and_stop();
  endtask
  // One Avalon access, held until waitrequest is sampled low
  task automatic bus(input logic wr_en, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk_in);
    avs_address_in <= a;
    avs_writedata_in <= d;
    avs_byteenable_in <= be;
    avs_write_in <= wr_en;
    avs_read_in <= !wr_en;
    n = 0;
    do begin
      @(posedge clk_in);
      n++;
    end while (avs_waitrequest_out !== 1'b0 && n < 50);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in <= 1'b0;
    if (avs_waitrequest_out !== 1'b0) timeout("bus");
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, 4'hf, q);
    chk(what, e, q);
  endtask
  // Same word repeated until the filter history is steady
  task automatic stream(input logic [11:0] a, input int cnt, output logic [23:0] last);
    int n;
    u_far.got.delete();
    repeat (cnt) u_far.send(a, 12'h000);
    n = 0;
    while (u_far.got.size() < cnt && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (u_far.got.size() < cnt) timeout("stream");
    last = u_far.got[$];
  endtask
  task automatic load_bank(input logic [7:0] base, input logic [31:0] ctr, input logic [31:0] side);
    for (int i = 0; i < 9; i++) begin
      wr(base + 8'(4 * i), (i == 4) ? ctr : side);
    end
  endtask
  // Reset values, unmapped place, lanes off, 18-bit center word
  task automatic check_regs();
    logic [31:0] q;
    rd_chk("ctrl", 8'h00, 32'h0);       // Bypass after reset
    rd_chk("status", 8'h04, 32'h0);     // Bypass after reset
    wr(8'h20, 32'hffffffff);
    rd_chk("unmapped", 8'h20, 32'h0);
    bus(1'b1, 8'h00, 32'h7f, 4'h0, q);
    rd_chk("ctrl_no_lanes", 8'h00, 32'h0);
    wr(8'h50, 32'h1ffff);
    rd_chk("center_word", 8'h50, 32'h1ffff);   // Largest positive 18-bit center value
  endtask
  // Every mode code against side taps of 1/1024 (A) and 1/512 (B)
  task automatic check_modes();
    logic [6:0]  ctl [6] = '{7'h6c, 7'h62, 7'h6e, 7'h6a, 7'h66, 7'h61};
    logic [23:0] ex [6] = '{24'h100000, 24'h102000, 24'h101001, 24'h101002,
                            24'h100000, 24'h100000};
    logic [1:0]  st [6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h0};
    logic [23:0] last;
    load_bank(8'h40, 32'h10000, 32'h40);   // Loaded before enable
    load_bank(8'h80, 32'h0, 32'h80);       // Loaded before enable
    for (int m = 0; m < 6; m++) begin
      wr(8'h00, {25'h0, ctl[m]});   // Link mode taken as matching
      stream(12'h100, 10, last);
      chk("mode_out", {8'h0, ex[m]}, {8'h0, last});   // Per mode
      rd_chk("mode_stat", 8'h04, {30'h0, st[m]});     // Active mode
    end
  endtask
  // Negative side taps at every weight code, code 7 clamped
  task automatic check_weights();
    logic [23:0] last;
    logic [11:0] ea;
    load_bank(8'h40, 32'h0, 32'hc00);
    for (int w = 0; w < 8; w++) begin
      ea = 12'(-(1 << (11 - ((w > 6) ? 6 : w))));
      wr(8'h00, 32'h2 | 32'(w << 4));
      stream(12'h100, 10, last);
      chk("weight_out", {8'h0, ea, 12'h0}, {8'h0, last});   // Shared weight
    end
    // Unit center tap with silent sides passes the sample through
    load_bank(8'h40, 32'h10000, 32'h0);
    load_bank(8'h80, 32'h10000, 32'h0);
    wr(8'h00, 32'h2);
    stream(12'h100, 10, last);
    chk("unit_out", {8'h0, 24'h100000}, {8'h0, last});
  endtask
  // Sink stalls: FIFO fills, input refuses, then drains in order
  task automatic check_fifo();
    int n;
    wr(8'h00, 32'h0);
    u_far.got.delete();
    stall <= 1'b1;
    for (int i = 0; i < 6; i++) u_far.send(12'h100 + 12'(i), 12'h800 + 12'(i));
    repeat (4) @(posedge clk_in);
    chk("in_ready", 32'h0, {31'h0, smp_ready_out});
    chk("none_out", 32'h0, 32'(u_far.got.size()));
    rd_chk("fifo_full", 8'h04, 32'h10);
    wr(8'h04, 32'hffffffff);
    rd_chk("status_ro", 8'h04, 32'h10);
    stall <= 1'b0;
    n = 0;
    while (u_far.got.size() < 6 && n < 50) begin
      @(posedge clk_in);
      n++;
    end
    if (u_far.got.size() < 6) timeout("drain");
    for (int i = 0; i < 6; i++) begin
      chk("order", {8'h0, 12'h100 + 12'(i), 12'h800 + 12'(i)}, {8'h0, u_far.got[i]});
    end
    rd_chk("fifo_empty", 8'h04, 32'h0);
  endtask
  // Reset, then the scenarios in turn
  initial begin
    n_fail = 0;
    comparisons = 0;
    rstn_in = 1'b0;
    stall = 1'b0;
    avs_address_in = 8'h00;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0;
    avs_byteenable_in = 4'hf;
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    check_regs();
    check_modes();
    check_weights();
    check_fifo();
    report_and_stop();
  end
endmodule
`default_nettype wire
